/* File: logic/mmsp_memory_map.sv */
// module: memory map decode, code source select and stack pointer
`timescale 1ns/1ns
`default_nettype none
module mmsp_memory_map (
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  // strap pin, asynchronous
  input  wire logic                     external_access_select_in,
  // extended stack enable, chip_config_reg top bit
  input  wire logic                     ext_stack_en_in,
  // code fetch
  input  wire logic                     fetch_req_in,
  input  wire logic [mmsp_pkg::CODE_AW-1:0] fetch_addr_in,
  input  wire logic [7:0]               code_int_data_in,
  input  wire logic [7:0]               code_ext_data_in,
  output logic                          code_int_rd_out,
  output logic                          code_ext_rd_out,
  output logic [7:0]                    fetch_data_out,
  output logic                          exec_external_out,
  // data access
  input  wire logic                     acc_valid_in,
  input  wire logic                     acc_write_in,
  input  wire mmsp_pkg::mmsp_kind_t     acc_kind_in,
  input  wire logic [7:0]               acc_addr_in,
  input  wire logic [7:0]               acc_wdata_in,
  input  wire logic [1:0]               bank_sel_in,
  output logic [7:0]                    acc_rdata_out,
  output logic                          acc_ack_out,
  // forwarded special_function_register access
  output logic                          sfr_rd_out,
  output logic                          sfr_wr_out,
  output logic                          sfr_bit_out,
  output logic [7:0]                    sfr_addr_out,
  output logic [7:0]                    sfr_wdata_out,
  // stack
  input  wire logic                     push_in,
  input  wire logic                     pop_in,
  input  wire logic [7:0]               push_data_in,
  output logic [7:0]                    pop_data_out,
  output logic [mmsp_pkg::SP_W-1:0]     stack_pointer_out
);
  import mmsp_pkg::*;

  // ************************************************
  // storage
  // ************************************************
  logic [7:0] iram [IRAM_DEPTH];   // general-purpose ram
  logic [7:0] onchip_extended_ram [ONCHIP_EXTENDED_RAM_DEPTH];   // onchip_extended_ram

  // ************************************************
  // code source strap
  // ************************************************
  logic ea_meta_r;   // first synchroniser stage
  logic ea_sync_r;   // second synchroniser stage
  logic ext_exec_r;  // latched code source

  // two-stage synchroniser, free running
  always_ff @(posedge clk_in) begin
    ea_meta_r <= external_access_select_in;
    ea_sync_r <= ea_meta_r;
  end

  // source is sampled only while reset is held
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_exec_r <= ~ea_sync_r;
    end
  end

  assign exec_external_out = ext_exec_r;

  // ************************************************
  // code fetch
  // ************************************************
  logic       in_nop_zone;  // top 2 kB of code space
  logic [7:0] fetch_data_r; // returned opcode byte

  assign in_nop_zone     = (fetch_addr_in >= CODE_NOP_BASE);
  assign code_ext_rd_out = fetch_req_in & ext_exec_r;
  // internal memory is not read inside the no-op zone
  assign code_int_rd_out = fetch_req_in & ~ext_exec_r
                           & ~in_nop_zone;

  // fetch result, one cycle after the request
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fetch_data_r <= NOP_OPCODE;
    end else if (fetch_req_in) begin
      if (ext_exec_r) begin
        fetch_data_r <= code_ext_data_in;
      end else if (in_nop_zone) begin
        fetch_data_r <= NOP_OPCODE;
      end else begin
        fetch_data_r <= code_int_data_in;
      end
    end
  end

  assign fetch_data_out = fetch_data_r;

  // ************************************************
  // data address decode
  // ************************************************
  logic       ram_hit;   // access lands in ram
  logic       sp_lo_hit; // stack_pointer_low selected
  logic       sp_hi_hit; // stack_pointer_high selected
  logic       sfr_fwd;   // passed on to register space
  logic       is_bit;    // single-bit access
  logic [7:0] ram_addr;  // ram byte address
  logic [2:0] bit_pos;   // bit within the byte
  logic [7:0] sfr_addr;  // forwarded register address

  // map each access kind onto ram or registers
  always_comb begin
    ram_hit   = 1'b0;
    sp_lo_hit = 1'b0;
    sp_hi_hit = 1'b0;
    sfr_fwd   = 1'b0;
    is_bit    = 1'b0;
    ram_addr  = acc_addr_in;
    bit_pos   = acc_addr_in[2:0];
    sfr_addr  = acc_addr_in;
    case (acc_kind_in)
      MMSP_K_DIRECT: begin
        // lower half is ram, upper half is registers
        if (!acc_addr_in[7]) begin
          ram_hit = 1'b1;
        end else if (acc_addr_in == SP_LOW_ADDR) begin
          sp_lo_hit = 1'b1;
        end else if (acc_addr_in == SP_HIGH_ADDR) begin
          sp_hi_hit = 1'b1;
        end else begin
          sfr_fwd = 1'b1;
        end
      end
      MMSP_K_INDIRECT: begin
        // all 256 bytes reachable
        ram_hit = 1'b1;
      end
      MMSP_K_REGISTER: begin
        // bank picks one of four eight-byte groups
        ram_addr = {BANK_PAD, bank_sel_in, acc_addr_in[2:0]};
        ram_hit  = 1'b1;
      end
      MMSP_K_BIT: begin
        is_bit = 1'b1;
        if (!acc_addr_in[7]) begin
          // bits 00..7f live in bytes 20h..2fh
          ram_addr = BIT_RAM_BASE + {4'h0, acc_addr_in[6:3]};
          ram_hit  = 1'b1;
        end else begin
          sfr_addr = {acc_addr_in[7:3], 3'h0};
          sfr_fwd  = 1'b1;
        end
      end
      default: begin
        ram_hit = 1'b0;
      end
    endcase
  end

  logic acc_wr;     // qualified write
  logic acc_rd;     // qualified read
  logic sp_reg_wr;  // software writes the pointer

  assign acc_wr    = acc_valid_in & acc_write_in;
  assign acc_rd    = acc_valid_in & ~acc_write_in;
  assign sp_reg_wr = acc_wr & (sp_lo_hit | sp_hi_hit);

  // read-modify-write value for bit stores
  logic [7:0] bit_merge;
  always_comb begin
    bit_merge          = iram[ram_addr];
    bit_merge[bit_pos] = acc_wdata_in[0];
  end

  // ************************************************
  // stack pointer
  // ************************************************
  logic [7:0]      sp_lo_r;  // stack_pointer_low
  logic [2:0]      sp_hi_r;  // stack_pointer_high bits
  logic [SP_W-1:0] sp_full;  // whole pointer
  logic [SP_W-1:0] sp_up;    // value after a push
  logic [SP_W-1:0] sp_dn;    // value after a pop
  logic [SP_W-1:0] push_adr; // byte written by a push
  logic [SP_W-1:0] pop_adr;  // byte read by a pop
  logic            push_go;  // push accepted
  logic            pop_go;   // pop accepted
  logic [7:0]      sp_lo_up; // low byte plus one
  logic [7:0]      sp_lo_dn; // low byte minus one

  assign sp_full  = {sp_hi_r, sp_lo_r};
  assign sp_lo_up = sp_lo_r + SP_LOW_ONE;
  assign sp_lo_dn = sp_lo_r - SP_LOW_ONE;

  // extended mode carries into bits 10:8
  always_comb begin
    if (ext_stack_en_in) begin
      sp_up    = sp_full + SP_ONE;
      sp_dn    = sp_full - SP_ONE;
      push_adr = sp_up;
      pop_adr  = sp_full;
    end else begin
      sp_up    = {sp_hi_r, sp_lo_up};
      sp_dn    = {sp_hi_r, sp_lo_dn};
      push_adr = {SP_HIGH_RST, sp_lo_up};
      pop_adr  = {SP_HIGH_RST, sp_lo_r};
    end
  end

  // a register write to the pointer beats a stack op
  assign push_go = push_in & ~sp_reg_wr;
  assign pop_go  = pop_in & ~push_in & ~sp_reg_wr;

  // pointer update
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sp_lo_r <= SP_LOW_RST;
      sp_hi_r <= SP_HIGH_RST;
    end else if (acc_wr && sp_lo_hit) begin
      sp_lo_r <= acc_wdata_in;
    end else if (acc_wr && sp_hi_hit) begin
      sp_hi_r <= acc_wdata_in[SP_HI_W-1:0];
    end else if (push_go) begin
      {sp_hi_r, sp_lo_r} <= sp_up;
    end else if (pop_go) begin
      {sp_hi_r, sp_lo_r} <= sp_dn;
    end
  end

  assign stack_pointer_out = sp_full;

  // ************************************************
  // memory writes
  // ************************************************
  // general-purpose ram: core stores and low stack
  always_ff @(posedge clk_in) begin
    if (acc_wr && ram_hit) begin
      iram[ram_addr] <= is_bit ? bit_merge : acc_wdata_in;
    end
    if (push_go && (push_adr < ONCHIP_EXTENDED_RAM_STK_BASE)) begin
      iram[push_adr[7:0]] <= push_data_in;
    end
  end

  // extended ram above 0100h holds the deep stack
  always_ff @(posedge clk_in) begin
    if (push_go && (push_adr >= ONCHIP_EXTENDED_RAM_STK_BASE)) begin
      onchip_extended_ram[push_adr] <= push_data_in;
    end
  end

  // pop returns the byte under the pointer
  logic [7:0] pop_data_r;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pop_data_r <= NOP_OPCODE;
    end else if (pop_go) begin
      if (pop_adr < ONCHIP_EXTENDED_RAM_STK_BASE) begin
        pop_data_r <= iram[pop_adr[7:0]];
      end else begin
        pop_data_r <= onchip_extended_ram[pop_adr];
      end
    end
  end

  assign pop_data_out = pop_data_r;

  // ************************************************
  // read answers and forwarding
  // ************************************************
  logic [7:0] rdata_r; // read data to the core
  logic       ack_r;   // access served here

  // internal read path
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_r <= 8'h00;
      ack_r   <= 1'b0;
    end else begin
      ack_r <= acc_valid_in & (ram_hit | sp_lo_hit | sp_hi_hit);
      if (acc_rd && sp_lo_hit) begin
        rdata_r <= sp_lo_r;
      end else if (acc_rd && sp_hi_hit) begin
        rdata_r <= {SP_HIGH_PAD, sp_hi_r};
      end else if (acc_rd && ram_hit && is_bit) begin
        rdata_r <= {7'h00, iram[ram_addr][bit_pos]};
      end else if (acc_rd && ram_hit) begin
        rdata_r <= iram[ram_addr];
      end
    end
  end

  assign acc_rdata_out = rdata_r;
  assign acc_ack_out   = ack_r;

  logic       sfr_rd_r;
  logic       sfr_wr_r;
  logic       sfr_bit_r;
  logic [7:0] sfr_addr_r;
  logic [7:0] sfr_wdata_r;

  // direct upper-half accesses other than the pointer registers, and upper bit accesses, leave the block
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sfr_rd_r    <= 1'b0;
      sfr_wr_r    <= 1'b0;
      sfr_bit_r   <= 1'b0;
      sfr_addr_r  <= 8'h00;
      sfr_wdata_r <= 8'h00;
    end else begin
      sfr_rd_r  <= acc_rd & sfr_fwd;
      sfr_wr_r  <= acc_wr & sfr_fwd;
      sfr_bit_r <= acc_valid_in & sfr_fwd & is_bit;
      if (acc_valid_in && sfr_fwd) begin
        sfr_addr_r  <= sfr_addr;
        sfr_wdata_r <= acc_wdata_in;
      end
    end
  end

  assign sfr_rd_out    = sfr_rd_r;
  assign sfr_wr_out    = sfr_wr_r;
  assign sfr_bit_out   = sfr_bit_r;
  assign sfr_addr_out  = sfr_addr_r;
  assign sfr_wdata_out = sfr_wdata_r;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_push_only;
    push_in && !sp_reg_wr;
  endsequence

  sequence s_pop_only;
    pop_in && !push_in && !sp_reg_wr;
  endsequence

  a_ext_fetch_sel: assert property (
    fetch_req_in && ext_exec_r |-> code_ext_rd_out && !code_int_rd_out)
    else $error("external fetch not selected");

  a_int_fetch_sel: assert property (
    fetch_req_in && !ext_exec_r && !in_nop_zone
    |-> code_int_rd_out && !code_ext_rd_out)
    else $error("internal fetch not selected");

  a_nop_zone: assert property (
    fetch_req_in && !ext_exec_r && in_nop_zone
    |=> fetch_data_out == NOP_OPCODE)
    else $error("no-op zone returned other data");

  a_source_held: assert property (
    1'b1 |=> $stable(exec_external_out))
    else $error("code source changed outside reset");

  a_sp_reset: assert property (
    $fell(rst_in) |-> stack_pointer_out == {SP_HIGH_RST, SP_LOW_RST})
    else $error("pointer not 07h after reset");

  a_short_wrap: assert property (
    s_push_only and (!ext_stack_en_in && sp_lo_r == 8'hff)
    |=> sp_lo_r == 8'h00 && $stable(sp_hi_r))
    else $error("8-bit pointer did not wrap");

  a_ext_carry: assert property (
    s_push_only and (ext_stack_en_in && sp_full == 11'h0ff)
    |=> stack_pointer_out == ONCHIP_EXTENDED_RAM_STK_BASE)
    else $error("extended pointer did not carry");

  a_upper_direct: assert property (
    acc_valid_in && acc_kind_in == MMSP_K_DIRECT && acc_addr_in[7]
    && acc_addr_in != SP_LOW_ADDR && acc_addr_in != SP_HIGH_ADDR
    |=> (sfr_rd_out || sfr_wr_out) && !acc_ack_out)
    else $error("direct upper access reached ram");

  a_high_pad_zero: assert property (
    acc_rd && acc_kind_in == MMSP_K_DIRECT
    && acc_addr_in == SP_HIGH_ADDR
    |=> acc_rdata_out[7:3] == SP_HIGH_PAD && acc_ack_out)
    else $error("unused pointer bits not zero");

  a_push_pop: assert property (
    s_push_only ##1 s_pop_only |=> pop_data_out == $past(push_data_in, 2))
    else $error("pop did not return pushed byte");

endmodule
`default_nettype wire

/* File: logic/mmsp_pkg.sv */
// package: constants and types for the memory map and stack pointer
// Summary of operation
// - select pin low at reset: external code
// - otherwise execute from internal program memory
// - internal fetches F800H-FFFFH return no-operation
// - lower 128 bytes: direct and indirect access
// - upper 128 bytes indirect only; direct hits registers
// - lowest 32 bytes form four register banks
// - bytes 20H-2FH also addressable as bits
// - pointer resets to 07H, push pre-increments
// - default 8-bit pointer wraps FFH to 00H
// - enable input switches to 11-bit pointer
// - extended pointer continues from 00FFH to 0100H
// - 1792 extended ram bytes serve as stack
// - pointer low byte at register address 81H
// - pointer bits 10:8 at register address B7H
// - stack anywhere, up to 2048 bytes deep
`default_nettype none
package mmsp_pkg;

  // ************************************************
  // widths and depths
  // ************************************************
  localparam int CODE_AW    = 16;   // program address width
  localparam int SP_W       = 11;   // extended pointer width
  localparam int SP_HI_W    = 3;    // extra pointer bits
  localparam int IRAM_DEPTH = 256;  // general-purpose ram bytes
  localparam int ONCHIP_EXTENDED_RAM_DEPTH = 2048; // on-chip extended ram bytes

  // ************************************************
  // program memory map
  // ************************************************
  localparam logic [15:0] CODE_NOP_BASE = 16'hf800; // no-op zone
  localparam logic [7:0]  NOP_OPCODE    = 8'h00;    // no-operation

  // ************************************************
  // data memory map
  // ************************************************
  localparam logic [7:0]  BIT_RAM_BASE  = 8'h20;  // bit area start
  localparam logic [2:0]  BANK_PAD      = 3'h0;   // bank region top
  localparam logic [10:0] ONCHIP_EXTENDED_RAM_STK_BASE = 11'h100; // stack in onchip_extended_ram

  // ************************************************
  // register offsets and reset values
  // ************************************************
  localparam logic [7:0] SP_LOW_ADDR  = 8'h81; // stack_pointer_low
  localparam logic [7:0] SP_HIGH_ADDR = 8'hb7; // stack_pointer_high
  localparam logic [7:0] SP_LOW_RST   = 8'h07; // low byte reset
  localparam logic [2:0] SP_HIGH_RST  = 3'h0;  // high bits reset
  localparam logic [4:0] SP_HIGH_PAD  = 5'h00; // unused high bits
  localparam logic [10:0] SP_ONE      = 11'h001; // pointer step
  localparam logic [7:0] SP_LOW_ONE   = 8'h01;   // low byte step

  // ************************************************
  // access kinds from the core
  // ************************************************
  typedef enum logic [1:0] {
    MMSP_K_DIRECT   = 2'h0, // direct byte address
    MMSP_K_INDIRECT = 2'h1, // indirect via pointer register
    MMSP_K_REGISTER = 2'h2, // working register r0..
    MMSP_K_BIT      = 2'h3  // single-bit address
  } mmsp_kind_t;

endpackage
`default_nettype wire

/* File: bench/mmsp_code_mem_model.sv */
// partner model: internal and external program memory on the fetch path
`timescale 1ns/1ns
`default_nettype none
module mmsp_code_mem_model (
  input  wire logic        clk_in,
  input  wire logic        int_rd_in,
  input  wire logic        ext_rd_in,
  input  wire logic [15:0] addr_in,
  output logic      [7:0]  int_data_out,
  output logic      [7:0]  ext_data_out
);
  logic [7:0] int_last_r = 8'h00; // last internal byte driven
  logic [7:0] ext_last_r = 8'h00; // last external byte driven
  // selected memory answers this cycle; an idle one shows a moving pattern
  always_comb begin
    int_data_out = int_rd_in ? (addr_in[7:0] ^ 8'h5a) : ~int_last_r;
    ext_data_out = ext_rd_in ? (addr_in[7:0] ^ 8'ha5) : ~ext_last_r;
  end
  // remember what was on the lines so an idle bus keeps toggling
  always_ff @(posedge clk_in) begin
    int_last_r <= int_data_out;
    ext_last_r <= ext_data_out;
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// testbench: memory map, code source and stack pointer scenarios
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mmsp_pkg::*;
  // ************************************************
  // signals
  // ************************************************
  logic        clk, rst, strap, ext_en, f_req, ci_rd, ce_rd, exec_ext;
  logic [15:0] f_addr;
  logic [7:0]  ci_data, ce_data, f_data, a_addr, a_wdata, a_rdata;
  logic        a_valid, a_wr, a_ack, s_rd, s_wr, s_bit, push, pop;
  logic [7:0]  s_addr, s_wdata, p_data, pop_data;
  logic [1:0]  bank;
  logic [10:0] sp;
  mmsp_kind_t  a_kind;
  int          fail_count = 0; // mismatches seen
  int          comparisons = 0; // checks made
  // design under test
  mmsp_memory_map u_mmsp_memory_map (
    .clk_in(clk), .rst_in(rst), .external_access_select_in(strap),
    .ext_stack_en_in(ext_en), .fetch_req_in(f_req), .fetch_addr_in(f_addr),
    .code_int_data_in(ci_data), .code_ext_data_in(ce_data),
    .code_int_rd_out(ci_rd), .code_ext_rd_out(ce_rd),
    .fetch_data_out(f_data), .exec_external_out(exec_ext),
    .acc_valid_in(a_valid), .acc_write_in(a_wr), .acc_kind_in(a_kind),
    .acc_addr_in(a_addr), .acc_wdata_in(a_wdata), .bank_sel_in(bank),
    .acc_rdata_out(a_rdata), .acc_ack_out(a_ack), .sfr_rd_out(s_rd),
    .sfr_wr_out(s_wr), .sfr_bit_out(s_bit), .sfr_addr_out(s_addr),
    .sfr_wdata_out(s_wdata), .push_in(push), .pop_in(pop),
    .push_data_in(p_data), .pop_data_out(pop_data),
    .stack_pointer_out(sp));
  // program memory partner
  mmsp_code_mem_model u_mmsp_code_mem_model (
    .clk_in(clk), .int_rd_in(ci_rd), .ext_rd_in(ce_rd), .addr_in(f_addr),
    .int_data_out(ci_data), .ext_data_out(ce_data));
  // ************************************************
  // shared tasks
  // ************************************************
  // compare one value and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask
  // closing report
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // reset for 12 cycles with the strap held
  task automatic do_reset(input logic s);
    @(posedge clk);
    #1;
    strap = s;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
  endtask
  // one data access; outputs are checked by the caller after return
  task automatic acc(input mmsp_kind_t k, input logic w,
                     input logic [7:0] ad, input logic [7:0] wd);
    @(posedge clk);
    #1;
    a_valid = 1'b1;
    a_wr = w;
    a_kind = k;
    a_addr = ad;
    a_wdata = wd;
    @(posedge clk);
    #1;
    a_valid = 1'b0;
  endtask
  // one fetch, strobes checked in the request cycle
  task automatic fetch(input logic [15:0] ad, input logic [7:0] exp,
                       input logic irq, input logic erq);
    @(posedge clk);
    #1;
    f_req = 1'b1;
    f_addr = ad;
    #1;
    chk(16'(ci_rd), 16'(irq), "internal strobe");
    chk(16'(ce_rd), 16'(erq), "external strobe");
    @(posedge clk);
    #1;
    f_req = 1'b0;
    chk(16'(f_data), 16'(exp), "fetched byte");
  endtask
  // one stack operation
  task automatic stk(input logic pu, input logic po, input logic [7:0] d);
    @(posedge clk);
    #1;
    push = pu;
    pop = po;
    p_data = d;
    @(posedge clk);
    #1;
    push = 1'b0;
    pop = 1'b0;
  endtask
  // ************************************************
  // scenarios
  // ************************************************
  // pointer registers after reset
  task automatic t_regs;
    do_reset(1'b1);
    chk(16'(sp), 16'h007, "reset pointer");
    acc(MMSP_K_DIRECT, 1'b0, 8'h81, 8'h00);
    chk(16'(a_rdata), 16'h07, "low byte");
    chk(16'(a_ack), 16'h1, "low ack");
    acc(MMSP_K_DIRECT, 1'b1, 8'hb7, 8'hff);
    acc(MMSP_K_DIRECT, 1'b0, 8'hb7, 8'h00);
    chk(16'(a_rdata), 16'h07, "high byte");
    chk(16'(sp), 16'h707, "pointer high bits");
    $display("regs test done");
  endtask
  // code source select and the no-operation zone
  task automatic t_fetch;
    do_reset(1'b1);
    chk(16'(exec_ext), 16'h0, "internal mode");
    fetch(16'h1234, 8'h34 ^ 8'h5a, 1'b1, 1'b0);
    fetch(16'hf7ff, 8'hff ^ 8'h5a, 1'b1, 1'b0);
    fetch(16'hf800, 8'h00, 1'b0, 1'b0);
    fetch(16'hffff, 8'h00, 1'b0, 1'b0);
    strap = 1'b0;
    fetch(16'h0044, 8'h44 ^ 8'h5a, 1'b1, 1'b0);
    do_reset(1'b0);
    chk(16'(exec_ext), 16'h1, "external mode");
    fetch(16'hf900, 8'h00 ^ 8'ha5, 1'b0, 1'b1);
    strap = 1'b1;
    fetch(16'h0012, 8'h12 ^ 8'ha5, 1'b0, 1'b1);
    chk(16'(exec_ext), 16'h1, "mode held");
    $display("fetch test done");
  endtask
  // lower and upper halves of the ram
  task automatic t_ram;
    acc(MMSP_K_DIRECT, 1'b1, 8'h10, 8'h3c);
    chk(16'(a_ack), 16'h1, "direct low ack");
    acc(MMSP_K_INDIRECT, 1'b0, 8'h10, 8'h00);
    chk(16'(a_rdata), 16'h3c, "indirect low");
    acc(MMSP_K_INDIRECT, 1'b1, 8'h90, 8'hc3);
    chk(16'(s_wr), 16'h0, "indirect upper kept");
    acc(MMSP_K_DIRECT, 1'b0, 8'h90, 8'h00);
    chk(16'({a_ack, s_rd, s_addr}), 16'h190, "direct upper fwd");
    acc(MMSP_K_DIRECT, 1'b1, 8'h90, 8'h11);
    chk(16'({s_wr, s_wdata}), 16'h111, "direct upper write");
    acc(MMSP_K_INDIRECT, 1'b0, 8'h90, 8'h00);
    chk(16'(a_rdata), 16'hc3, "indirect upper");
    $display("ram test done");
  endtask
  // every register bank
  task automatic t_bank;
    for (int b = 0; b < 4; b++) begin
      bank = 2'(b);
      acc(MMSP_K_REGISTER, 1'b1, {5'h00, bank, 1'b1}, 8'(8'h40 + b));
      acc(MMSP_K_INDIRECT, 1'b0, {3'h0, bank, bank, 1'b1}, 8'h00);
      chk(16'(a_rdata), 16'(8'h40 + b), "bank register");
    end
    $display("bank test done");
  endtask
  // bit area and forwarded bit access
  task automatic t_bit;
    acc(MMSP_K_INDIRECT, 1'b1, 8'h21, 8'h00);
    acc(MMSP_K_BIT, 1'b1, 8'h0a, 8'h01);
    acc(MMSP_K_INDIRECT, 1'b0, 8'h21, 8'h00);
    chk(16'(a_rdata), 16'h04, "bit into byte");
    acc(MMSP_K_BIT, 1'b0, 8'h0a, 8'h00);
    chk(16'(a_rdata), 16'h01, "bit read");
    acc(MMSP_K_BIT, 1'b1, 8'h7f, 8'h01);
    acc(MMSP_K_INDIRECT, 1'b0, 8'h2f, 8'h00);
    chk(16'(a_rdata[7]), 16'h1, "last bit");
    acc(MMSP_K_BIT, 1'b0, 8'h93, 8'h00);
    chk(16'({s_rd, s_bit, s_addr}), 16'h390, "bit fwd");
    $display("bit test done");
  endtask
  // push, pop, wrap and extended pointer
  task automatic t_stack;
    do_reset(1'b1);
    stk(1'b1, 1'b0, 8'h5e);
    chk(16'(sp), 16'h008, "first push");
    acc(MMSP_K_INDIRECT, 1'b0, 8'h08, 8'h00);
    chk(16'(a_rdata), 16'h5e, "first byte");
    stk(1'b0, 1'b1, 8'h00);
    chk(16'({sp, pop_data}), 16'h075e, "pop");
    acc(MMSP_K_DIRECT, 1'b1, 8'h81, 8'hff);
    stk(1'b1, 1'b0, 8'h77);
    chk(16'(sp), 16'h000, "short wrap");
    acc(MMSP_K_INDIRECT, 1'b0, 8'h00, 8'h00);
    chk(16'(a_rdata), 16'h77, "wrapped byte");
    ext_en = 1'b1;
    acc(MMSP_K_DIRECT, 1'b1, 8'h81, 8'hff);
    stk(1'b1, 1'b0, 8'h99);
    chk(16'(sp), 16'h100, "extended step");
    acc(MMSP_K_INDIRECT, 1'b0, 8'h00, 8'h00);
    chk(16'(a_rdata), 16'h77, "ram untouched");
    stk(1'b0, 1'b1, 8'h00);
    chk(16'({sp, pop_data}), 16'hff99, "extended pop");
    acc(MMSP_K_DIRECT, 1'b1, 8'hb7, 8'h07);
    acc(MMSP_K_DIRECT, 1'b1, 8'h81, 8'hfe);
    stk(1'b1, 1'b0, 8'h4d);
    chk(16'(sp), 16'h7ff, "deepest slot");
    stk(1'b0, 1'b1, 8'h00);
    chk(16'(pop_data), 16'h4d, "deepest byte");
    ext_en = 1'b0;
    // push then pop on the next edge, high bits ignored for address
    @(posedge clk);
    #1;
    push = 1'b1;
    p_data = 8'hb4;
    @(posedge clk);
    #1;
    push = 1'b0;
    pop = 1'b1;
    @(posedge clk);
    #1;
    pop = 1'b0;
    chk(16'({sp, pop_data}), 16'hfeb4, "back-to-back pop");
    // push and pop together: only the push is taken
    stk(1'b1, 1'b1, 8'h3a);
    chk(16'(sp), 16'h7ff, "push wins");
    stk(1'b0, 1'b1, 8'h00);
    chk(16'({sp, pop_data}), 16'hfe3a, "pushed byte back");
    $display("stack test done");
  endtask
  // ************************************************
  // clock, main sequence, watchdog
  // ************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    strap = 1'b1;
    ext_en = 1'b0;
    f_req = 1'b0;
    f_addr = 16'h0000;
    a_valid = 1'b0;
    a_wr = 1'b0;
    a_kind = MMSP_K_DIRECT;
    a_addr = 8'h00;
    a_wdata = 8'h00;
    bank = 2'h0;
    push = 1'b0;
    pop = 1'b0;
    p_data = 8'h00;
    t_regs;
    t_fetch;
    t_ram;
    t_bank;
    t_bit;
    t_stack;
    end_sim;
  end
  // hang guard
  initial begin
    #500000;
    fail_count++;
    end_sim;
  end
endmodule
`default_nettype wire
